// ### core/fnma_pkg.sv
`default_nettype none
package fnma_pkg;
  // ------------------------------------------------------------------
  // Register byte offsets on the Wishbone slave.
  // ------------------------------------------------------------------
  localparam int         FNMA_ADR_W       = 9;
  localparam logic [8:0] FNMA_INSN_OFS    = 9'h000;
  localparam logic [8:0] FNMA_STATCTL_OFS = 9'h004;
  localparam logic [8:0] FNMA_CFLAGS_OFS  = 9'h008;
  localparam logic [8:0] FNMA_BUSY_OFS    = 9'h00c;
  localparam logic [8:0] FNMA_IRQ_ST_OFS  = 9'h010;
  localparam logic [8:0] FNMA_IRQ_CLR_OFS = 9'h014;
  localparam logic [8:0] FNMA_IRQ_EN_OFS  = 9'h018;
  localparam int         FNMA_FPR_BIT     = 8;
  // ------------------------------------------------------------------
  // Instruction word fields and encodings.
  // ------------------------------------------------------------------
  localparam logic [5:0] FNMA_OP_DBL   = 6'h3f;
  localparam logic [5:0] FNMA_OP_SGL   = 6'h3b;
  localparam logic [4:0] FNMA_XO_NMADD = 5'h1f;
  localparam int         FNMA_CR1_LSB  = 24;
  // ------------------------------------------------------------------
  // Event bits, rounding modes and reset values.
  // ------------------------------------------------------------------
  localparam int         FNMA_EV_W       = 3;
  localparam int         FNMA_EV_DONE    = 0;
  localparam int         FNMA_EV_INVALID = 1;
  localparam int         FNMA_EV_ILLEGAL = 2;
  localparam logic [1:0] FNMA_RND_NEAR   = 2'h0;
  localparam logic [1:0] FNMA_RND_ZERO   = 2'h1;
  localparam logic [1:0] FNMA_RND_PINF   = 2'h2;
  localparam logic [2:0] FNMA_IRQ_EN_RST = 3'h0;
  localparam logic [31:0] FNMA_CFLAGS_RST = 32'h0;
  localparam logic [16:0] FNMA_STATCTL_RST = 17'h0;
  // ------------------------------------------------------------------
  // Floating-point format constants and result class codes.
  // ------------------------------------------------------------------
  localparam logic signed [13:0] FNMA_EXP_BIAS = 14'sd1023;
  localparam logic signed [13:0] FNMA_DP_EMIN  = 14'sd1;
  localparam logic signed [13:0] FNMA_DP_EMAX  = 14'sd2046;
  localparam logic signed [13:0] FNMA_SP_EMIN  = 14'sd897;
  localparam logic signed [13:0] FNMA_SP_EMAX  = 14'sd1150;
  localparam logic [10:0] FNMA_EXP_ONES  = 11'h7ff;
  localparam logic [62:0] FNMA_DP_MAXMAG = 63'h7fefffffffffffff;
  localparam logic [62:0] FNMA_SP_MAXMAG = 63'h47efffffe0000000;
  localparam logic [63:0] FNMA_DEF_QNAN  = 64'h7ff8000000000000;
  localparam logic [4:0]  FNMA_CLS_QNAN  = 5'h11;
  localparam logic [4:0]  FNMA_CLS_NINF  = 5'h09;
  localparam logic [4:0]  FNMA_CLS_NNORM = 5'h08;
  localparam logic [4:0]  FNMA_CLS_NZERO = 5'h12;
  localparam logic [4:0]  FNMA_CLS_PZERO = 5'h02;
  localparam logic [4:0]  FNMA_CLS_PNORM = 5'h04;
  localparam logic [4:0]  FNMA_CLS_PINF  = 5'h05;
  // ------------------------------------------------------------------
  // Types.
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       fex;
    logic       fx;
    logic       vx;
    logic       xx;
    logic       ux;
    logic       ox;
    logic       vximz;
    logic       vxisi;
    logic       vxsnan;
    logic [4:0] result_class_field;
    logic       invalid_op_enable;
    logic [1:0] rounding_mode_field;
  } fnma_fp_status_control_reg_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [8:0]  adr;
    logic [31:0] dat;
  } fnma_wb_req_t;
  typedef enum logic [1:0] {FNMA_IDLE = 2'b01, FNMA_EXEC = 2'b10} fnma_state_t;
endpackage
`default_nettype wire

// ### core/fnma_unit.sv
`default_nettype none
// Behaviour
// - Multiply source A by source C, then add source B.
// - Keep all 106 product fraction bits unrounded through the add.
// - Shift the raw sum left until its leading significand bit is one.
// - Round to target precision under the rounding mode field.
// - Negate the rounded result, then write it to the destination.
// - A propagated quiet NaN keeps its sign.
// - Default NaN from a disabled invalid operation has sign zero, not negated.
// - A quieted signalling NaN keeps its original sign.
// - Set result class from the result, unless invalid with enable set.
// - Record form updates condition flags; plain form leaves them alone.
// - Single-precision variant rounds the same sequence to single precision.
module fnma_unit
  import fnma_pkg::*;
(
  input  wire logic         CLK_IN,
  input  wire logic         SRST_IN,
  input  wire fnma_wb_req_t WB_REQ_IN,
  output logic              WB_ACK_OUT,
  output logic [31:0]       WB_DAT_OUT,
  output logic              IRQ_OUT
);
  localparam int W = 164;
  // ------------------------------------------------------------------
  // State.
  // ------------------------------------------------------------------
  logic [63:0]           fpr_r [32];
  logic [63:0]           fpr_nxt [32];
  fnma_state_t           state_r, state_nxt;
  fnma_fp_status_control_reg_t           fp_status_control_reg_r, fp_status_control_reg_nxt;
  logic [31:0]           condition_flags_reg_r, condition_flags_reg_nxt;
  logic [4:0]            dest_fp_reg_r, dest_fp_reg_nxt;
  logic [4:0]            src_mult_a_r, src_mult_a_nxt;
  logic [4:0]            src_addend_r, src_addend_nxt;
  logic [4:0]            src_mult_c_r, src_mult_c_nxt;
  logic                  sp_r, sp_nxt;
  logic                  rec_r, rec_nxt;
  logic [FNMA_EV_W-1:0]  ev_r, ev_nxt;
  logic [FNMA_EV_W-1:0]  en_r, en_nxt;
  logic                  ack_r, ack_nxt;
  logic [31:0]           rdat_r, rdat_nxt;
  // Datapath intermediates.
  logic [63:0]           opa, opb, opc, res, fin;
  logic [105:0]          prod;
  logic [W-1:0]          pfr, bfr, pf, bf, mag, norm;
  logic signed [13:0]    pe, be, dexp, emax, exn, exr, emin, emaxt;
  logic [7:0]            lz;
  logic [52:0]           kept, mant;
  logic [53:0]           ulp, rsum;
  logic                  ps, msign, zsign, eff_sub, p_big, pinf, pz, imz, isi;
  logic                  any_snan, invalid, keep, grd, stk, lsb, up, to_max;
  logic                  n_ox, n_ux, n_xx;
  logic [4:0]            cls;
  // ------------------------------------------------------------------
  // Operand decoding helpers.
  // ------------------------------------------------------------------
  function automatic logic is_nan(input logic [63:0] x);
    is_nan = (x[62:52] == FNMA_EXP_ONES) && (x[51:0] != 52'h0);
  endfunction
  function automatic logic is_snan(input logic [63:0] x);
    is_snan = is_nan(x) && !x[51];
  endfunction
  function automatic logic is_inf(input logic [63:0] x);
    is_inf = (x[62:52] == FNMA_EXP_ONES) && (x[51:0] == 52'h0);
  endfunction
  function automatic logic is_zero(input logic [63:0] x);
    is_zero = (x[62:0] == 63'h0);
  endfunction
  function automatic logic signed [13:0] exp_of(input logic [63:0] x);
    exp_of = (x[62:52] == 11'h0) ? 14'sd1 : $signed({3'h0, x[62:52]});
  endfunction
  function automatic logic [52:0] man_of(input logic [63:0] x);
    man_of = {x[62:52] != 11'h0, x[51:0]};
  endfunction
  function automatic logic [63:0] quiet(input logic [63:0] x);
    quiet = {x[63:52], 1'b1, x[50:0]};
  endfunction
  // Right shift that folds every lost bit into bit 0.
  function automatic logic [W-1:0] shr_st(input logic [W-1:0] x, input logic [12:0] n);
    if (n >= 13'(W)) begin
      shr_st = {{(W-1){1'b0}}, |x};
    end else begin
      shr_st = (x >> n) | {{(W-1){1'b0}}, |(x & ~({W{1'b1}} << n))};
    end
  endfunction
  function automatic logic [7:0] clz(input logic [W-1:0] x);
    clz = 8'(W);
    for (int i = 0; i < W; i++) begin
      if (x[i]) clz = 8'(W - 1 - i);
    end
  endfunction
  // Byte-lane merge of a bus write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = s[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
  endfunction
  // ------------------------------------------------------------------
  // Fused negative multiply-add datapath.
  // ------------------------------------------------------------------
  always_comb begin
    opa = fpr_r[src_mult_a_r];
    opb = fpr_r[src_addend_r];
    opc = fpr_r[src_mult_c_r];
    any_snan = is_snan(opa) | is_snan(opb) | is_snan(opc);
    ps = opa[63] ^ opc[63];
    pinf = is_inf(opa) | is_inf(opc);
    pz = is_zero(opa) | is_zero(opc);
    imz = (is_inf(opa) & is_zero(opc)) | (is_zero(opa) & is_inf(opc));
    eff_sub = ps ^ opb[63];
    isi = pinf & is_inf(opb) & eff_sub;
    invalid = any_snan | imz | isi;
    // Full-width product, aligned with the addend in one wide frame.
    prod = {53'h0, man_of(opa)} * {53'h0, man_of(opc)};
    pfr = {2'b00, prod, 56'h0};
    bfr = {3'b000, man_of(opb), 108'h0};
    pe = exp_of(opa) + exp_of(opc) - FNMA_EXP_BIAS;
    be = exp_of(opb);
    dexp = pe - be;
    p_big = is_zero(opb) | (!pz & !dexp[13]);
    emax = p_big ? pe : be;
    pf = p_big ? pfr : shr_st(pfr, 13'(-dexp));
    bf = p_big ? shr_st(bfr, dexp[12:0]) : bfr;
    // Signed-magnitude addition of product and addend.
    if (!eff_sub) begin
      mag = pf + bf;
      msign = ps;
    end else if (pf >= bf) begin
      mag = pf - bf;
      msign = ps;
    end else begin
      mag = bf - pf;
      msign = opb[63];
    end
    zsign = (ps == opb[63]) ? ps : (fp_status_control_reg_r.rounding_mode_field == 2'h3);
    // Normalise so the leading one sits at the frame top.
    lz = clz(mag);
    norm = mag << lz;
    exn = emax + 14'sd3 - $signed({6'h0, lz});
    // Round at the target precision.
    kept = sp_r ? {norm[163:140], 29'h0} : norm[163:111];
    grd = sp_r ? norm[139] : norm[110];
    stk = sp_r ? |norm[138:0] : |norm[109:0];
    lsb = sp_r ? norm[140] : norm[111];
    ulp = sp_r ? 54'h20000000 : 54'h1;
    case (fp_status_control_reg_r.rounding_mode_field)
      FNMA_RND_NEAR: up = grd & (stk | lsb);
      FNMA_RND_ZERO: up = 1'b0;
      FNMA_RND_PINF: up = (grd | stk) & !msign;
      default:       up = (grd | stk) & msign;
    endcase
    rsum = {1'b0, kept} + (up ? ulp : 54'h0);
    mant = rsum[53] ? rsum[53:1] : rsum[52:0];
    exr = rsum[53] ? exn + 14'sd1 : exn;
    emin = sp_r ? FNMA_SP_EMIN : FNMA_DP_EMIN;
    emaxt = sp_r ? FNMA_SP_EMAX : FNMA_DP_EMAX;
    to_max = (fp_status_control_reg_r.rounding_mode_field == FNMA_RND_ZERO) |
             ((fp_status_control_reg_r.rounding_mode_field == FNMA_RND_PINF) & msign) |
             ((fp_status_control_reg_r.rounding_mode_field == 2'h3) & !msign);
    // Special operands take priority over the arithmetic result.
    keep = 1'b0;
    n_ox = 1'b0;
    n_ux = 1'b0;
    n_xx = 1'b0;
    if (is_nan(opa) | is_nan(opb) | is_nan(opc)) begin
      res = quiet(is_nan(opa) ? opa : (is_nan(opb) ? opb : opc));
      keep = 1'b1;
    end else if (imz | isi) begin
      res = FNMA_DEF_QNAN;
      keep = 1'b1;
    end else if (pinf) begin
      res = {ps, FNMA_EXP_ONES, 52'h0};
    end else if (is_inf(opb)) begin
      res = {opb[63], FNMA_EXP_ONES, 52'h0};
    end else if (mag == '0) begin
      res = {zsign, 63'h0};
    end else if (exr < emin) begin
      res = {msign, 63'h0};
      n_ux = 1'b1;
      n_xx = 1'b1;
    end else if (exr > emaxt) begin
      res = to_max ? {msign, sp_r ? FNMA_SP_MAXMAG : FNMA_DP_MAXMAG}
                   : {msign, FNMA_EXP_ONES, 52'h0};
      n_ox = 1'b1;
      n_xx = 1'b1;
    end else begin
      res = {msign, exr[10:0], mant[51:0]};
      n_xx = grd | stk;
    end
    fin = keep ? res : {~res[63], res[62:0]};
    // Class and sign of the value that is written back.
    if (is_nan(fin)) begin
      cls = FNMA_CLS_QNAN;
    end else if (is_inf(fin)) begin
      cls = fin[63] ? FNMA_CLS_NINF : FNMA_CLS_PINF;
    end else if (is_zero(fin)) begin
      cls = fin[63] ? FNMA_CLS_NZERO : FNMA_CLS_PZERO;
    end else begin
      cls = fin[63] ? FNMA_CLS_NNORM : FNMA_CLS_PNORM;
    end
  end
  // ------------------------------------------------------------------
  // Bus slave, sequencing and write-back.
  // ------------------------------------------------------------------
  logic              bus_req, wr, rd, idle;
  logic [8:0]        adr;
  logic [31:0]       wd;
  logic [5:0]        ins_op;
  logic [FNMA_EV_W-1:0] ev_set, ev_clr;
  fnma_fp_status_control_reg_t       fs;
  always_comb begin
    fpr_nxt = fpr_r;
    state_nxt = state_r;
    fp_status_control_reg_nxt = fp_status_control_reg_r;
    condition_flags_reg_nxt = condition_flags_reg_r;
    dest_fp_reg_nxt = dest_fp_reg_r;
    src_mult_a_nxt = src_mult_a_r;
    src_addend_nxt = src_addend_r;
    src_mult_c_nxt = src_mult_c_r;
    sp_nxt = sp_r;
    rec_nxt = rec_r;
    en_nxt = en_r;
    ev_set = '0;
    ev_clr = '0;
    fs = fp_status_control_reg_r;
    bus_req = WB_REQ_IN.cyc & WB_REQ_IN.stb & !ack_r;
    wr = bus_req & WB_REQ_IN.we;
    rd = bus_req & !WB_REQ_IN.we;
    adr = WB_REQ_IN.adr;
    wd = WB_REQ_IN.dat;
    idle = (state_r == FNMA_IDLE);
    ins_op = wd[31:26];
    ack_nxt = bus_req;
    rdat_nxt = 32'h0;
    // Address decode; unmapped addresses ack and read as zero.
    if (adr[FNMA_FPR_BIT]) begin
      rdat_nxt = adr[2] ? fpr_r[adr[7:3]][63:32] : fpr_r[adr[7:3]][31:0];
      if (wr && idle && adr[2]) begin
        fpr_nxt[adr[7:3]][63:32] = merge(fpr_r[adr[7:3]][63:32], wd, WB_REQ_IN.sel);
      end else if (wr && idle) begin
        fpr_nxt[adr[7:3]][31:0] = merge(fpr_r[adr[7:3]][31:0], wd, WB_REQ_IN.sel);
      end
    end else if (adr == FNMA_INSN_OFS) begin
      if (wr && idle) begin
        if ((ins_op == FNMA_OP_DBL || ins_op == FNMA_OP_SGL) && wd[5:1] == FNMA_XO_NMADD) begin
          dest_fp_reg_nxt = wd[25:21];
          src_mult_a_nxt = wd[20:16];
          src_addend_nxt = wd[15:11];
          src_mult_c_nxt = wd[10:6];
          sp_nxt = (ins_op == FNMA_OP_SGL);
          rec_nxt = wd[0];
          state_nxt = FNMA_EXEC;
        end else begin
          ev_set[FNMA_EV_ILLEGAL] = 1'b1;
        end
      end
    end else if (adr == FNMA_STATCTL_OFS) begin
      rdat_nxt = {15'h0, fp_status_control_reg_r};
      if (wr) fs = fnma_fp_status_control_reg_t'(17'(merge({15'h0, fs}, wd, WB_REQ_IN.sel)));
    end else if (adr == FNMA_CFLAGS_OFS) begin
      rdat_nxt = condition_flags_reg_r;
      if (wr) condition_flags_reg_nxt = merge(condition_flags_reg_r, wd, WB_REQ_IN.sel);
    end else if (adr == FNMA_BUSY_OFS) begin
      rdat_nxt = {31'h0, !idle};
    end else if (adr == FNMA_IRQ_ST_OFS) begin
      rdat_nxt = {29'h0, ev_r};
    end else if (adr == FNMA_IRQ_CLR_OFS) begin
      if (wr && WB_REQ_IN.sel[0]) ev_clr = wd[FNMA_EV_W-1:0];
    end else if (adr == FNMA_IRQ_EN_OFS) begin
      rdat_nxt = {29'h0, en_r};
      if (wr && WB_REQ_IN.sel[0]) en_nxt = wd[FNMA_EV_W-1:0];
    end
    if (!rd) rdat_nxt = 32'h0;
    // Execute cycle: exception bits are set after any bus write.
    if (state_r == FNMA_EXEC) begin
      {fs.vxsnan, fs.vximz, fs.vxisi} = {fs.vxsnan, fs.vximz, fs.vxisi} | {any_snan, imz, isi};
      {fs.ox, fs.ux, fs.xx} = {fs.ox, fs.ux, fs.xx} | {n_ox, n_ux, n_xx};
      fs.fx = fs.fx | invalid | n_ox | n_ux | n_xx;
      fs.vx = fs.vxsnan | fs.vximz | fs.vxisi;
      fs.fex = fs.fex | (invalid & fs.invalid_op_enable);
      if (!(invalid && fs.invalid_op_enable)) begin
        fpr_nxt[dest_fp_reg_r] = fin;
        fs.result_class_field = cls;
      end
      if (rec_r) begin
        condition_flags_reg_nxt[FNMA_CR1_LSB +: 4] = {fs.fx, fs.fex, fs.vx, fs.ox};
      end
      ev_set[FNMA_EV_DONE] = 1'b1;
      ev_set[FNMA_EV_INVALID] = invalid;
      state_nxt = FNMA_IDLE;
    end
    fp_status_control_reg_nxt = fs;
    // Sticky events: a new event wins over a clear in the same cycle.
    ev_nxt = (ev_r & ~ev_clr) | ev_set;
  end
  // Registers only.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      fpr_r <= '{default: 64'h0};
      state_r <= FNMA_IDLE;
      fp_status_control_reg_r <= fnma_fp_status_control_reg_t'(FNMA_STATCTL_RST);
      condition_flags_reg_r <= FNMA_CFLAGS_RST;
      dest_fp_reg_r <= 5'h0;
      src_mult_a_r <= 5'h0;
      src_addend_r <= 5'h0;
      src_mult_c_r <= 5'h0;
      sp_r <= 1'b0;
      rec_r <= 1'b0;
      ev_r <= '0;
      en_r <= FNMA_IRQ_EN_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      fpr_r <= fpr_nxt;
      state_r <= state_nxt;
      fp_status_control_reg_r <= fp_status_control_reg_nxt;
      condition_flags_reg_r <= condition_flags_reg_nxt;
      dest_fp_reg_r <= dest_fp_reg_nxt;
      src_mult_a_r <= src_mult_a_nxt;
      src_addend_r <= src_addend_nxt;
      src_mult_c_r <= src_mult_c_nxt;
      sp_r <= sp_nxt;
      rec_r <= rec_nxt;
      ev_r <= ev_nxt;
      en_r <= en_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end
  // Outputs.
  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = rdat_r;
  assign IRQ_OUT    = |(ev_r & en_r);
endmodule // fnma_unit
`default_nettype wire

// ### dv/fnma_unit_monitor.sv
`default_nettype none
module fnma_monitor
  import fnma_pkg::*;
(
  input wire logic         CLK_IN,
  input wire logic         SRST_IN,
  input wire fnma_wb_req_t WB_REQ_IN,
  input wire logic         WB_ACK_OUT,
  input wire logic [31:0]  WB_DAT_OUT,
  input wire logic         IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take;
  logic       wr_insn;
  logic [2:0] en_r;
  logic [2:0] en_nxt;
  // --------------------------------------------------------------------
  // Helper logic.
  // --------------------------------------------------------------------
  // A request is taken when it is presented and no answer is pending.
  assign take    = WB_REQ_IN.cyc && WB_REQ_IN.stb && !WB_ACK_OUT;
  assign wr_insn = take && WB_REQ_IN.we && (WB_REQ_IN.adr == FNMA_INSN_OFS);
  // Shadow of the interrupt enable register, rebuilt from the bus writes.
  always_comb begin
    en_nxt = en_r;
    if (take && WB_REQ_IN.we && WB_REQ_IN.adr == FNMA_IRQ_EN_OFS && WB_REQ_IN.sel[0]) begin
      en_nxt = WB_REQ_IN.dat[2:0];
    end
  end
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      en_r <= FNMA_IRQ_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end
  // --------------------------------------------------------------------
  // Properties.
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);
  // The bus answers once, one cycle after taking a request, with quiet data otherwise.
  a_ack_after_take: assert property (take |=> WB_ACK_OUT)
    else $error("ack missing after a taken request");
  a_ack_one_cycle: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack stood longer than one cycle");
  a_ack_has_req: assert property (WB_ACK_OUT |-> $past(WB_REQ_IN.cyc && WB_REQ_IN.stb))
    else $error("ack without a request");
  a_dat_quiet: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
    else $error("read data not zero outside ack");
  a_empty_read_zero: assert property (WB_ACK_OUT && $past(!WB_REQ_IN.we &&
    (WB_REQ_IN.adr == FNMA_INSN_OFS || (WB_REQ_IN.adr >= 9'h01c && WB_REQ_IN.adr < 9'h100)))
    |-> WB_DAT_OUT == 32'h0) else $error("instruction or unmapped read not zero");
  // The interrupt line follows the enabled status bits.
  a_irq_enabled: assert property (IRQ_OUT |-> en_r != 3'h0)
    else $error("interrupt raised with all sources masked");
  a_mask_drops_irq: assert property (take && WB_REQ_IN.we && WB_REQ_IN.sel[0] &&
    WB_REQ_IN.adr == FNMA_IRQ_EN_OFS && WB_REQ_IN.dat[2:0] == 3'h0 |=> !IRQ_OUT)
    else $error("interrupt stayed high after masking");
  a_done_irq: assert property (wr_insn && WB_REQ_IN.dat[5:1] == FNMA_XO_NMADD &&
    (WB_REQ_IN.dat[31:26] == FNMA_OP_DBL || WB_REQ_IN.dat[31:26] == FNMA_OP_SGL) &&
    en_r[FNMA_EV_DONE] |-> ##[1:3] IRQ_OUT) else $error("done interrupt missing");
  a_illegal_irq: assert property (wr_insn && WB_REQ_IN.dat[5:1] != FNMA_XO_NMADD &&
    en_r[FNMA_EV_ILLEGAL] |-> ##[1:3] IRQ_OUT) else $error("illegal interrupt missing");
endmodule // fnma_monitor

bind fnma_unit fnma_monitor i_fnma_monitor (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN),
  .WB_REQ_IN(WB_REQ_IN), .WB_ACK_OUT(WB_ACK_OUT), .WB_DAT_OUT(WB_DAT_OUT), .IRQ_OUT(IRQ_OUT));
`default_nettype wire

// ### dv/fnma_unit_test.sv
`default_nettype none
module fnma_unit_test
  import fnma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  fnma_wb_req_t req = '0;
  logic         ack;
  logic [31:0]  dat;
  logic         irq;
  logic [31:0]  rd;
  int           num_errors = 0;
  int           checks = 0;
  int           cycles = 0;
  logic [31:0]  dlo [4] = '{32'h2, 32'h2, 32'h3, 32'h2};
  logic [31:0]  slo [4] = '{32'h0, 32'h0, 32'h20000000, 32'h0};
  logic [8:0]   zofs [6] = '{FNMA_STATCTL_OFS, FNMA_CFLAGS_OFS, FNMA_IRQ_EN_OFS,
                             FNMA_IRQ_ST_OFS, FNMA_INSN_OFS, 9'h020};
  // Clock of 40 ns and a cycle ceiling that cuts a hang short.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      give_verdict();
    end
  end
  fnma_unit i_fnma_unit (.CLK_IN(clk), .SRST_IN(srst), .WB_REQ_IN(req), .WB_ACK_OUT(ack),
                         .WB_DAT_OUT(dat), .IRQ_OUT(irq));
  // --------------------------------------------------------------------
  // Tasks.
  // --------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compares one result word.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle; read data is taken at the edge that sees ack.
  task automatic wb(input logic we, input logic [8:0] adr, input logic [31:0] wd);
    @(posedge clk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = dat;
    req <= '0;
  endtask
  task automatic rdchk(input logic [8:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    chk(rd, exp);
  endtask
  task automatic setf(input logic [4:0] n, input logic [63:0] v);
    wb(1'b1, {1'b1, n, 3'h0}, v[31:0]);
    wb(1'b1, {1'b1, n, 3'h4}, v[63:32]);
  endtask
  task automatic chkf(input logic [4:0] n, input logic [63:0] v);
    rdchk({1'b1, n, 3'h0}, v[31:0]);
    rdchk({1'b1, n, 3'h4}, v[63:32]);
  endtask
  // Issues one instruction: destination, source A, addend, source C, record bit.
  task automatic exe(input logic [5:0] op, input logic [4:0] d, input logic [4:0] a,
                     input logic [4:0] b, input logic [4:0] c, input logic rc);
    wb(1'b1, FNMA_INSN_OFS, {op, d, a, b, c, FNMA_XO_NMADD, rc});
  endtask
  // The interrupt line is looked at mid-cycle, once register updates have landed.
  task automatic irqchk(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask
  // --------------------------------------------------------------------
  // Tests.
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    wb(1'b1, 9'h020, 32'hffffffff);
    foreach (zofs[i]) rdchk(zofs[i], 32'h0);
    $display("test reset finished");
    setf(5'd1, 64'h4000000000000000);
    setf(5'd2, 64'h4008000000000000);
    setf(5'd3, 64'h3ff0000000000000);
    exe(FNMA_OP_DBL, 5'd31, 5'd1, 5'd3, 5'd2, 1'b0);
    chkf(5'd31, 64'hc01c000000000000);
    rdchk(FNMA_STATCTL_OFS, 32'({FNMA_CLS_NNORM, 3'h0}));
    rdchk(FNMA_BUSY_OFS, 32'h0);
    setf(5'd4, 64'h3ff0000000000001);
    setf(5'd5, 64'hbff0000000000002);
    exe(FNMA_OP_DBL, 5'd6, 5'd4, 5'd5, 5'd4, 1'b0);
    chkf(5'd6, 64'hb970000000000000);
    setf(5'd7, 64'h0);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, FNMA_STATCTL_OFS, 32'(m));
      exe(FNMA_OP_DBL, 5'd8, 5'd4, 5'd7, 5'd4, 1'b0);
      chkf(5'd8, {32'hbff00000, dlo[m]});
      exe(FNMA_OP_SGL, 5'd9, 5'd4, 5'd7, 5'd4, 1'b0);
      chkf(5'd9, {32'hbff00000, slo[m]});
    end
    $display("test arithmetic finished");
    wb(1'b1, FNMA_STATCTL_OFS, 32'h0);
    setf(5'd10, 64'hfff8000000000123);
    exe(FNMA_OP_DBL, 5'd11, 5'd10, 5'd3, 5'd3, 1'b0);
    chkf(5'd11, 64'hfff8000000000123);
    rdchk(FNMA_STATCTL_OFS, 32'({FNMA_CLS_QNAN, 3'h0}));
    setf(5'd12, 64'h7ff0000000000005);
    exe(FNMA_OP_DBL, 5'd13, 5'd12, 5'd3, 5'd3, 1'b0);
    chkf(5'd13, 64'h7ff8000000000005);
    setf(5'd14, 64'h7ff0000000000000);
    wb(1'b1, FNMA_CFLAGS_OFS, 32'h50505050);
    wb(1'b1, FNMA_IRQ_CLR_OFS, 32'h7);
    exe(FNMA_OP_DBL, 5'd15, 5'd14, 5'd3, 5'd7, 1'b0);
    chkf(5'd15, FNMA_DEF_QNAN);
    rdchk(FNMA_CFLAGS_OFS, 32'h50505050);
    rdchk(FNMA_IRQ_ST_OFS, 32'h3);
    exe(FNMA_OP_DBL, 5'd15, 5'd14, 5'd3, 5'd7, 1'b1);
    rdchk(FNMA_CFLAGS_OFS, 32'h5a505050);
    wb(1'b1, FNMA_STATCTL_OFS, 32'h4);
    exe(FNMA_OP_DBL, 5'd13, 5'd14, 5'd3, 5'd7, 1'b0);
    chkf(5'd13, 64'h7ff8000000000005);
    rdchk(FNMA_STATCTL_OFS, 32'h1c404);
    $display("test special values finished");
    wb(1'b1, FNMA_IRQ_CLR_OFS, 32'h7);
    wb(1'b1, FNMA_IRQ_EN_OFS, 32'h1);
    irqchk(1'b0);
    exe(FNMA_OP_DBL, 5'd16, 5'd1, 5'd3, 5'd2, 1'b0);
    irqchk(1'b1);
    wb(1'b1, FNMA_IRQ_EN_OFS, 32'h0);
    irqchk(1'b0);
    wb(1'b1, FNMA_IRQ_EN_OFS, 32'h5);
    irqchk(1'b1);
    wb(1'b1, FNMA_IRQ_CLR_OFS, 32'h1);
    irqchk(1'b0);
    wb(1'b1, FNMA_INSN_OFS, 32'hfc000000);
    irqchk(1'b1);
    wb(1'b1, FNMA_IRQ_CLR_OFS, 32'h4);
    irqchk(1'b0);
    $display("test interrupts finished");
    give_verdict();
  end
endmodule // fnma_unit_test
`default_nettype wire
